// ---- core/teng_consts.svh ----
// Offsets, field positions and reset values of the transfer engine.
// Assumes inclusion by bare name from the engine core.
`ifndef TENG_CONSTS_SVH
`define TENG_CONSTS_SVH
`define TENG_OFF_CTRL 8'h00
`define TENG_OFF_MODE_A 8'h04
`define TENG_OFF_MODE_B 8'h08
`define TENG_OFF_SRC 8'h0c
`define TENG_OFF_DST 8'h10
`define TENG_OFF_COUNT 8'h14
`define TENG_OFF_STOP 8'h18
`define TENG_OFF_IRQ_ST 8'h1c
`define TENG_OFF_IRQ_MASK 8'h20
`define TENG_OFF_VECTOR 8'h24
`define TENG_CTRL_SKIP 4
`define TENG_CTRL_RCHAIN 3
`define TENG_CTRL_FAULT 0
`define TENG_STOP_BIT 4
`define TENG_MB_CHAIN 7
`define TENG_MB_PER_TRANSFER_IRQ_SELECT 5
`define TENG_ST_DONE 0
`define TENG_ST_ERR 1
`define TENG_ST_CHAIN 2
`define TENG_MODE_REPEAT 2'h1
`define TENG_STEP_INC 2'h2
`define TENG_SIZE_BAD 2'h3
`define TENG_STOP_RESET 8'h00
`define TENG_RESP_OKAY 2'h0
`define TENG_RESP_SLVERR 2'h2
`endif

// ---- core/teng_core.sv ----
// Transfer engine control: activation, info load or skip, pointer
// stepping, counting, chaining, fault flag and AXI4-Lite registers.
// Assumes a memory mover that acknowledges each requested transfer.
`timescale 1ns/1ps
`default_nettype none
`include "teng_consts.svh"

// Operation
// - With skip on, a repeat of the previous vector reuses info.
// - Repeat-chain off blocks a chain after a repeat-mode transfer.
// - The fault flag reads 0 while no error interrupt is pending.
// - Source step field 10 increments the source pointer.
// - Pointer step is 1, 2 or 4 for unit size 00, 01 or 10.
// - The engine runs only while its clock-stop bit is 0.
// - Destination step 0x holds, 10 increments by unit size.
// - The counter holds transfers left before the task completes.
// - Without per-transfer select, interrupt only at count end.
// - Chain enable 0 starts no chained transfer.
module teng_core (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic act_req,
    input wire logic [7:0] act_vector,
    output logic act_ready,
    output logic xfer_req,
    output logic [31:0] xfer_src,
    output logic [31:0] xfer_dst,
    output logic [1:0] xfer_size,
    input wire logic xfer_ack,
    output logic chain_start,
    output logic irq
);
    // ****************************************************
    // Registers and engine state
    // ****************************************************
    logic [7:0] ctrl_q, mode_a_q, mode_b_q, stop_q, vec_q;
    logic [31:0] src_q, dst_q;
    logic [15:0] cnt_q;
    logic [2:0] irq_st_q, irq_mask_q, st_set;
    logic have_vec_q;
    logic [7:0] wa_q, wmode_b_q;
    logic [1:0] wsize_q, wsrc_step_q, wdst_step_q, wmd_q;
    logic [31:0] wsrc_q, wdst_q;
    logic [15:0] wcnt_q, wreload_q;
    teng_pkg::teng_state_t state_q;
    logic aw_have_q, w_have_q, do_write, rd_st;
    logic [7:0] awa_q;
    logic [31:0] wd_q;
    logic [31:0] step;
    logic running, bad_mode, last;

    // Clock gate stand-in: stop bit high freezes the engine
    assign running = ~stop_q[`TENG_STOP_BIT];
    assign act_ready = running && state_q == teng_pkg::ST_IDLE;

    // Unit size selects the pointer step
    always_comb begin
        case (wsize_q)
            2'h0: step = 32'h0000_0001;
            2'h1: step = 32'h0000_0002;
            2'h2: step = 32'h0000_0004;
            default: step = 32'h0000_0000;
        endcase
    end
    // Size 11 and step 11 have no meaning; they raise the fault
    assign bad_mode = wsize_q == `TENG_SIZE_BAD ||
        wsrc_step_q == 2'h3 || wdst_step_q == 2'h3 ||
        wmd_q == 2'h3 || wcnt_q == 16'h0000;
    assign last = wcnt_q == 16'h0001;

    // ****************************************************
    // Engine sequencer
    // ****************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= teng_pkg::ST_IDLE;
        end else if (running) begin
            case (state_q)
                teng_pkg::ST_IDLE: begin
                    if (act_req) begin
                        if (ctrl_q[`TENG_CTRL_SKIP] && have_vec_q &&
                            act_vector == vec_q) begin
                            state_q <= teng_pkg::ST_MOVE;
                        end else begin
                            state_q <= teng_pkg::ST_LOAD;
                        end
                    end
                end
                teng_pkg::ST_LOAD: state_q <= teng_pkg::ST_MOVE;
                teng_pkg::ST_MOVE: begin
                    state_q <= bad_mode ? teng_pkg::ST_IDLE :
                        teng_pkg::ST_WAIT;
                end
                teng_pkg::ST_WAIT: begin
                    if (xfer_ack) begin
                        state_q <= teng_pkg::ST_POST;
                    end
                end
                teng_pkg::ST_POST: state_q <= teng_pkg::ST_IDLE;
                default: state_q <= teng_pkg::ST_IDLE;
            endcase
        end
    end

    // Last vector kept so the next activation can be compared
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vec_q <= 8'h00;
            have_vec_q <= 1'b0;
        end else if (running && state_q == teng_pkg::ST_IDLE &&
            act_req) begin
            vec_q <= act_vector;
            have_vec_q <= 1'b1;
        end
    end

    // Working copy of transfer info; reused untouched on a skip
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wmode_b_q <= 8'h00;
            wmd_q <= 2'h0;
            wsize_q <= 2'h0;
            wsrc_step_q <= 2'h0;
            wdst_step_q <= 2'h0;
            wsrc_q <= 32'h0000_0000;
            wdst_q <= 32'h0000_0000;
            wcnt_q <= 16'h0000;
            wreload_q <= 16'h0000;
        end else if (running && state_q == teng_pkg::ST_LOAD) begin
            wmd_q <= mode_a_q[7:6];
            wsize_q <= mode_a_q[5:4];
            wsrc_step_q <= mode_a_q[3:2];
            wdst_step_q <= mode_b_q[3:2];
            wmode_b_q <= mode_b_q;
            wsrc_q <= src_q;
            wdst_q <= dst_q;
            wcnt_q <= cnt_q;
            wreload_q <= cnt_q;
        end else if (running && state_q == teng_pkg::ST_WAIT &&
            xfer_ack) begin
            if (wsrc_step_q == `TENG_STEP_INC) begin
                wsrc_q <= wsrc_q + step;
            end
            if (wdst_step_q == `TENG_STEP_INC) begin
                wdst_q <= wdst_q + step;
            end
            // Repeat mode reloads instead of finishing
            if (last && wmd_q == `TENG_MODE_REPEAT) begin
                wcnt_q <= wreload_q;
            end else begin
                wcnt_q <= wcnt_q - 16'h0001;
            end
        end
    end

    // Mover request held until acknowledged
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            xfer_req <= 1'b0;
            xfer_src <= 32'h0000_0000;
            xfer_dst <= 32'h0000_0000;
            xfer_size <= 2'h0;
        end else if (running && state_q == teng_pkg::ST_MOVE &&
            !bad_mode) begin
            xfer_req <= 1'b1;
            xfer_src <= wsrc_q;
            xfer_dst <= wdst_q;
            xfer_size <= wsize_q;
        end else if (xfer_ack) begin
            xfer_req <= 1'b0;
        end
    end

    // Engine events: fault at a refused move, done and chain after a transfer
    always_comb begin
        st_set = 3'h0;
        chain_start = 1'b0;
        if (running && state_q == teng_pkg::ST_MOVE && bad_mode) begin
            st_set[`TENG_ST_ERR] = 1'b1;
        end
        if (running && state_q == teng_pkg::ST_POST) begin
            // Count is already stepped; zero means the task ended
            if (wmode_b_q[`TENG_MB_PER_TRANSFER_IRQ_SELECT] || wcnt_q == 16'h0000 ||
                (wmd_q == `TENG_MODE_REPEAT && wcnt_q == wreload_q)) begin
                st_set[`TENG_ST_DONE] = 1'b1;
            end
            if (wmode_b_q[`TENG_MB_CHAIN] && (wmd_q != `TENG_MODE_REPEAT ||
                ctrl_q[`TENG_CTRL_RCHAIN])) begin
                chain_start = 1'b1;
                st_set[`TENG_ST_CHAIN] = 1'b1;
            end
        end
    end

    // ****************************************************
    // AXI4-Lite slave
    // ****************************************************
    assign awready = !aw_have_q && !bvalid;
    assign wready = !w_have_q && !bvalid;
    assign do_write = aw_have_q && w_have_q;
    assign arready = !rvalid;

    // Address and data taken in either order, then answered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awa_q <= 8'h00;
            wd_q <= 32'h0000_0000;
            wa_q <= 8'h00;
            bvalid <= 1'b0;
            bresp <= `TENG_RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_have_q <= 1'b1;
                awa_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_have_q <= 1'b1;
                wd_q <= wdata;
                wa_q <= {4'h0, wstrb};
            end
            if (do_write) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid <= 1'b1;
                bresp <= (awa_q > `TENG_OFF_VECTOR || awa_q[1:0] != 2'h0) ?
                    `TENG_RESP_SLVERR : `TENG_RESP_OKAY;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Software-visible info; the engine writes back after each completed transfer, not after a refused move
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= 8'h00;
            mode_a_q <= 8'h00;
            mode_b_q <= 8'h00;
            stop_q <= `TENG_STOP_RESET;
            irq_mask_q <= 3'h0;
            src_q <= 32'h0000_0000;
            dst_q <= 32'h0000_0000;
            cnt_q <= 16'h0000;
        end else begin
            if (do_write && wa_q[0]) begin
                case (awa_q)
                    `TENG_OFF_CTRL: ctrl_q <= wd_q[7:0] & 8'h18;
                    `TENG_OFF_MODE_A: mode_a_q <= wd_q[7:0] & 8'hfc;
                    `TENG_OFF_MODE_B: mode_b_q <= wd_q[7:0] & 8'hfc;
                    `TENG_OFF_STOP: stop_q <= wd_q[7:0] & 8'h10;
                    `TENG_OFF_IRQ_MASK: irq_mask_q <= wd_q[2:0];
                    default: ;
                endcase
            end
            if (do_write && awa_q == `TENG_OFF_SRC) begin
                src_q <= wd_q;
            end
            if (do_write && awa_q == `TENG_OFF_DST) begin
                dst_q <= wd_q;
            end
            if (do_write && awa_q == `TENG_OFF_COUNT) begin
                cnt_q <= wd_q[15:0];
            end
            // Engine write-back wins over a same-cycle software write
            if (running && state_q == teng_pkg::ST_POST) begin
                src_q <= wsrc_q;
                dst_q <= wdst_q;
                cnt_q <= wcnt_q;
            end
        end
    end

    // Read path; a status read clears what it returned
    assign rd_st = arvalid && arready && araddr == `TENG_OFF_IRQ_ST;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `TENG_RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= `TENG_RESP_OKAY;
            case (araddr)
                `TENG_OFF_CTRL: rdata <= {24'h0, ctrl_q[7:1],
                    irq_st_q[`TENG_ST_ERR]};
                `TENG_OFF_MODE_A: rdata <= {24'h0, mode_a_q};
                `TENG_OFF_MODE_B: rdata <= {24'h0, mode_b_q};
                `TENG_OFF_SRC: rdata <= src_q;
                `TENG_OFF_DST: rdata <= dst_q;
                `TENG_OFF_COUNT: rdata <= {16'h0, cnt_q};
                `TENG_OFF_STOP: rdata <= {24'h0, stop_q};
                `TENG_OFF_IRQ_ST: rdata <= {29'h0, irq_st_q};
                `TENG_OFF_IRQ_MASK: rdata <= {29'h0, irq_mask_q};
                `TENG_OFF_VECTOR: rdata <= {24'h0, vec_q};
                default: begin
                    rdata <= 32'h0000_0000;
                    rresp <= `TENG_RESP_SLVERR;
                end
            endcase
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // ****************************************************
    // Interrupt status
    // ****************************************************
    // Set wins over the read clear so no event is dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_st_q <= 3'h0;
        end else begin
            irq_st_q <= (rd_st ? 3'h0 : irq_st_q) | st_set;
        end
    end
    assign irq = |(irq_st_q & irq_mask_q);

    // ****************************************************
    // Checks
    // ****************************************************
    AST_SKIP: assert property (@(posedge aclk) disable iff (!aresetn)
        act_ready && act_req && ctrl_q[`TENG_CTRL_SKIP] && have_vec_q &&
        act_vector == vec_q |=> state_q == teng_pkg::ST_MOVE)
        else $error("skip did not bypass the info load");
    AST_NOSKIP: assert property (@(posedge aclk) disable iff (!aresetn)
        act_ready && act_req && !ctrl_q[`TENG_CTRL_SKIP]
        |=> state_q == teng_pkg::ST_LOAD)
        else $error("info load missed with skip off");
    AST_RCHAIN: assert property (@(posedge aclk) disable iff (!aresetn)
        chain_start && wmd_q == `TENG_MODE_REPEAT |-> ctrl_q[`TENG_CTRL_RCHAIN])
        else $error("chain after repeat transfer while disabled");
    AST_FAULT: assert property (@(posedge aclk) disable iff (!aresetn)
        rvalid && $past(araddr) == `TENG_OFF_CTRL && $past(arvalid && arready)
        |-> rdata[0] == $past(irq_st_q[`TENG_ST_ERR]))
        else $error("fault flag disagrees with error status");
    AST_SRC_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
        running && state_q == teng_pkg::ST_WAIT && xfer_ack &&
        wsrc_step_q == `TENG_STEP_INC && wsize_q == 2'h2
        |=> wsrc_q == $past(wsrc_q) + 32'h0000_0004)
        else $error("source pointer step wrong");
    AST_STOPPED: assert property (@(posedge aclk) disable iff (!aresetn)
        !running |=> $stable(state_q))
        else $error("engine moved while stopped");
    AST_VEC: assert property (@(posedge aclk) disable iff (!aresetn)
        act_ready && act_req |=> vec_q == $past(act_vector))
        else $error("activation vector not kept");
    AST_DST_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        state_q == teng_pkg::ST_WAIT && xfer_ack && !wdst_step_q[1]
        |=> $stable(wdst_q))
        else $error("fixed destination pointer moved");
    AST_DONE: assert property (@(posedge aclk) disable iff (!aresetn)
        st_set[`TENG_ST_DONE] && !wmode_b_q[`TENG_MB_PER_TRANSFER_IRQ_SELECT] &&
        wmd_q != `TENG_MODE_REPEAT |-> wcnt_q == 16'h0000)
        else $error("early completion interrupt");
    AST_CHAIN: assert property (@(posedge aclk) disable iff (!aresetn)
        chain_start |-> wmode_b_q[`TENG_MB_CHAIN])
        else $error("chain without chain enable");
endmodule
`default_nettype wire

// ---- core/teng_pkg.sv ----
// Types shared by the transfer engine core.
// Assumes the constants header sits beside it.
package teng_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LOAD = 3'b001,
        ST_MOVE = 3'b010,
        ST_WAIT = 3'b011,
        ST_POST = 3'b100
    } teng_state_t;
endpackage

// ---- sim/teng_core_tb_top.sv ----
// Self-checking bench for the transfer engine core.
// Assumes the mover model stands on the transfer request port.
`timescale 1ns/1ps
`default_nettype none
module teng_core_tb_top;
    // ****************************************
    // Stimulus and checks
    // ****************************************
    typedef struct {
        logic [7:0] ma;
        logic [7:0] mb;
        logic [31:0] ds;
        logic [31:0] dd;
        logic [3:0] dl;
    } teng_row_t;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, act_req = 0, xfer_ack, chain_start, irq;
    logic awready, wready, bvalid, arready, rvalid, act_ready, xfer_req;
    logic [7:0] awaddr = 0, araddr = 0, act_vector = 0;
    logic [31:0] wdata = 0, rdata, xfer_src, xfer_dst, seen_src, seen_dst;
    logic [31:0] rd;
    logic [3:0] wstrb = 0, delay = 0;
    logic [1:0] bresp, rresp, xfer_size, seen_size, rsp;
    int err_total = 0, cmp_count = 0, lat = 0, chain_cnt = 0, c0;
    // Rows: mode A, mode B, source step, destination step, mover stall
    teng_row_t rows[4] = '{'{8'h08, 8'h08, 1, 1, 0}, '{8'h18, 8'h00, 2, 0, 5},
        '{8'h20, 8'h08, 0, 4, 1}, '{8'h28, 8'h04, 4, 0, 0}};

    always #20 aclk = ~aclk;
    // Counts chain pulses so scenarios compare before and after
    always @(posedge aclk) if (chain_start === 1'b1) chain_cnt++;

    teng_core teng_core_inst (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .act_req(act_req),
        .act_vector(act_vector), .act_ready(act_ready), .xfer_req(xfer_req),
        .xfer_src(xfer_src), .xfer_dst(xfer_dst), .xfer_size(xfer_size),
        .xfer_ack(xfer_ack), .chain_start(chain_start), .irq(irq));
    teng_mover_model teng_mover_model_inst (.aclk(aclk), .aresetn(aresetn),
        .xfer_req(xfer_req), .xfer_src(xfer_src), .xfer_dst(xfer_dst),
        .xfer_size(xfer_size), .delay(delay), .xfer_ack(xfer_ack),
        .seen_src(seen_src), .seen_dst(seen_dst), .seen_size(seen_size));

    task automatic stop_test();
        if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask
    // A wait that ran out of its bound ends the run as a failure
    task automatic bound(input int i);
        if (i >= 100) begin
            err_total++;
            stop_test();
        end
    endtask
    // Handshakes are judged at the falling edge, released after the rise
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int i;
        logic ag, wg, bg;
        @(posedge aclk);
        awaddr <= a; awvalid <= 1; wdata <= d; wstrb <= 4'hf;
        wvalid <= 1; bready <= 1;
        for (i = 0; i < 100; i++) begin
            @(negedge aclk);
            ag = awvalid & awready; wg = wvalid & wready; bg = bvalid;
            rsp = bresp;
            @(posedge aclk);
            if (ag) awvalid <= 0;
            if (wg) wvalid <= 0;
            if (bg) begin
                bready <= 0;
                break;
            end
        end
        bound(i);
    endtask
    task automatic rdr(input logic [7:0] a);
        int i;
        logic ag, rg;
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        for (i = 0; i < 100; i++) begin
            @(negedge aclk);
            ag = arvalid & arready; rg = rvalid; rd = rdata; rsp = rresp;
            @(posedge aclk);
            if (ag) arvalid <= 0;
            if (rg) begin
                rready <= 0;
                break;
            end
        end
        bound(i);
    endtask
    task automatic idle_wait();
        int i;
        for (i = 0; i < 100; i++) begin
            @(negedge aclk);
            if (act_ready === 1'b1) break;
        end
        bound(i);
    endtask
    // Activate with a vector; lat is edges from take to transfer request
    task automatic activate(input logic [7:0] v, input bit mv);
        int i;
        idle_wait();
        @(posedge aclk);
        act_req <= 1; act_vector <= v;
        @(posedge aclk);
        act_req <= 0;
        if (mv) begin
            for (i = 0; i < 100; i++) begin
                @(negedge aclk);
                if (xfer_req === 1'b1) break;
            end
            bound(i);
            lat = i;
        end
        idle_wait();
    endtask

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        rdr(8'h00); chk(rd, 0);
        rdr(8'h18); chk(rd, 0);
        foreach (rows[k]) begin
            delay <= rows[k].dl;
            wr(8'h04, rows[k].ma); wr(8'h08, rows[k].mb);
            wr(8'h0c, 32'h100); wr(8'h10, 32'h200); wr(8'h14, 2);
            activate(8'h01, 1);
            chk(seen_src, 32'h100); chk(seen_size, rows[k].ma[5:4]);
            chk(seen_dst, 32'h200);
            rdr(8'h0c); chk(rd, 32'h100 + rows[k].ds);
            rdr(8'h10); chk(rd, 32'h200 + rows[k].dd);
            rdr(8'h14); chk(rd, 1); chk(rsp, 0);
        end
        // Done only at count end; read of status clears it
        wr(8'h20, 3); wr(8'h08, 0); wr(8'h14, 2);
        activate(8'h01, 1); chk(irq, 0);
        activate(8'h01, 1); chk(irq, 1);
        rdr(8'h1c); chk(rd, 1); chk(irq, 0);
        // Chain on and off, then repeat mode with the repeat-chain bit
        wr(8'h14, 8); c0 = chain_cnt;
        activate(8'h01, 1); chk(chain_cnt, c0);
        wr(8'h08, 8'h80); activate(8'h01, 1); chk(chain_cnt, c0 + 1);
        wr(8'h04, 8'h40); activate(8'h01, 1); chk(chain_cnt, c0 + 1);
        wr(8'h00, 8'h08); activate(8'h01, 1); chk(chain_cnt, c0 + 2);
        wr(8'h08, 0); rdr(8'h1c); wr(8'h14, 8); wr(8'h04, 0);
        // Skip the info read only for a repeated vector with skip on
        // Load takes two edges to the request, a skip only one
        wr(8'h00, 8'h10); activate(8'h05, 1); chk(lat, 2);
        activate(8'h05, 1); chk(lat, 1);
        rdr(8'h24); chk(rd, 5);
        activate(8'h06, 1); chk(lat, 2);
        wr(8'h00, 0); activate(8'h06, 1); chk(lat, 2);
        // Size 11 is refused and raises the fault
        wr(8'h04, 8'h30); activate(8'h07, 0); chk(irq, 1);
        rdr(8'h00); chk(rd, 1);
        rdr(8'h1c); chk(rd, 2); rdr(8'h00); chk(rd, 0);
        // Stop bit blocks activation, clearing it resumes
        wr(8'h18, 8'h10); @(negedge aclk); chk(act_ready, 0);
        wr(8'h18, 0); @(negedge aclk); chk(act_ready, 1);
        rdr(8'h30); chk(rsp, 2); chk(rd, 0);
        wr(8'h30, 1); chk(rsp, 2);
        // Repeat mode at its last unit reloads the count and reports done
        wr(8'h04, 8'h40); wr(8'h14, 1); activate(8'h08, 1);
        rdr(8'h1c); chk(rd, 1);
        rdr(8'h14); chk(rd, 1);
        // Mid-run reset clears control, count and the kept vector
        wr(8'h00, 8'h18); wr(8'h14, 5);
        @(posedge aclk);
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        rdr(8'h00); chk(rd, 0);
        rdr(8'h14); chk(rd, 0);
        rdr(8'h24); chk(rd, 0);
        @(negedge aclk); chk(act_ready, 1);
        stop_test();
    end
endmodule
`default_nettype wire

// ---- sim/teng_mover_model.sv ----
// Memory mover model facing the transfer engine's request port.
// Assumes one request at a time, held until acknowledged.
`timescale 1ns/1ps
`default_nettype none
module teng_mover_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic xfer_req,
    input wire logic [31:0] xfer_src,
    input wire logic [31:0] xfer_dst,
    input wire logic [1:0] xfer_size,
    input wire logic [3:0] delay,
    output logic xfer_ack,
    output logic [31:0] seen_src,
    output logic [31:0] seen_dst,
    output logic [1:0] seen_size
);
    // ****************************************
    // Acknowledge after a chosen stall
    // ****************************************
    logic [3:0] wait_q;

    // One-cycle ack; a slow mover holds the engine in its wait state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            xfer_ack <= 1'b0;
            wait_q <= 4'h0;
        end else if (xfer_ack) begin
            xfer_ack <= 1'b0;
        end else if (xfer_req && wait_q >= delay) begin
            xfer_ack <= 1'b1;
            wait_q <= 4'h0;
            seen_src <= xfer_src;
            seen_dst <= xfer_dst;
            seen_size <= xfer_size;
        end else if (xfer_req) begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule
`default_nettype wire
